// file: src/irq_wake_pkg.sv
// Purpose: Shared constants for the request and pin wake block.
// Assumes: APB with 32-bit data, one aligned word per register.
// Notes:   Printed offsets are not multiples of four, so they are indices.
package irq_wake_pkg;

   // ----------------------------------------------------------------------
   // Register indices and address width
   // ----------------------------------------------------------------------
   localparam logic [11:0] PIN_PEND_IDX   = 12'h0fc3;
   localparam logic [11:0] EDGE_POL_IDX   = 12'h0fcd;
   localparam logic [11:0] PORT_SEL_IDX   = 12'h0fce;
   localparam logic [11:0] PERIPH_IDX     = 12'h0fc0;
   localparam logic [11:0] CTRL_IDX       = 12'h0fcf;
   localparam logic [11:0] WAKE_EN_IDX    = 12'h0fd0;
   localparam logic [11:0] PORT_A_IN_IDX  = 12'h0fd1;
   localparam logic [11:0] PORT_D_IN_IDX  = 12'h0fd2;
   localparam int          ADDR_W         = 14;

   // ----------------------------------------------------------------------
   // Field positions and reset values
   // ----------------------------------------------------------------------
   localparam int          PERIPH_BITS    = 7;
   localparam int          CTRL_GIE       = 0;
   localparam int          CTRL_HALT      = 1;
   localparam int          CTRL_WAKE_FLAG = 2;
   localparam logic [7:0]  PEND_RESET     = 8'h00;
   localparam logic [7:0]  CFG_RESET      = 8'h00;

   // ----------------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------------
   localparam int          CLK_PERIOD_PS  = 5000;
   localparam int          GLITCH_PS      = 10000;
   localparam int          GLITCH_CYC     = (GLITCH_PS + CLK_PERIOD_PS - 1)
                                            / CLK_PERIOD_PS;
   localparam int          RECOVERY_CYC   = 16;

endpackage : irq_wake_pkg

// file: src/irq_request_and_pin_wake.sv
// Purpose: Collects peripheral and port pin requests, handles pin wake.
// Assumes: Pins are synchronous to ref_clk; APB master holds requests.
// Notes:   Registers answer with pready high in the first access cycle.
//
// Notes on behaviour
// RULE_01: A presented request sets its pending bit to one.
// RULE_02: With global enable set, pending requests go to the CPU.
// RULE_03: With global enable clear, pending bits stay readable for polling.
// RULE_04: Pin pending register, eight bits, index FC3H, resets to zero.
// RULE_05: Peripheral register holds seven source bits; one means pending.
// RULE_06: Each pin source has its own edge polarity setting.
// RULE_07: Polarity zero uses falling edge, one uses rising edge.
// RULE_08: External pulses must last over one clock to be sure.
// RULE_09: Each pin source picks the port A or port D pin.
// RULE_10: Any wake enabled pin level change starts halt recovery.
// RULE_11: Wake path rejects pulses shorter than about 10 ns.
// RULE_12: A pin caused recovery sets the halt wake flag.
// RULE_13: Port input data is not sampled while halted.
// RULE_14: Wake pin change recorded only if it lasts through recovery.
// RULE_15: Pending bits hold until cleared; software can also set them.
//
// Register access over APB was decided locally.
`timescale 1ns/100ps
module irq_request_and_pin_wake #(
   parameter int PINS      = 8,                 // Pins per port.
   parameter int RECOVERY  = irq_wake_pkg::RECOVERY_CYC // Recovery cycles.
) (
   input  wire logic                  ref_clk,      // System clock.
   input  wire logic                  rst_b,        // Async reset, low.
   input  wire logic [irq_wake_pkg::ADDR_W-1:0] paddr, // APB address.
   input  wire logic                  psel,         // APB select.
   input  wire logic                  penable,      // APB enable.
   input  wire logic                  pwrite,       // APB direction.
   input  wire logic [31:0]           pwdata,       // APB write data.
   output logic      [31:0]           prdata,       // APB read data.
   output logic                       pready,       // APB ready.
   output logic                       pslverr,      // APB error.
   input  wire logic [PINS-1:0]       port_a_pins,  // Port A inputs.
   input  wire logic [PINS-1:0]       port_d_pins,  // Port D inputs.
   input  wire logic [irq_wake_pkg::PERIPH_BITS-1:0] periph_req, // Pulses.
   input  wire logic                  halt_enter,   // CPU enters halt.
   output logic      [PINS-1:0]       pin_irq_to_cpu,    // Vectored pins.
   output logic [irq_wake_pkg::PERIPH_BITS-1:0] periph_irq_to_cpu, // Vectored.
   output logic                       halted,       // Halted state.
   output logic                       wake_start    // Recovery started.
);

   // ----------------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------------
   localparam int PB = irq_wake_pkg::PERIPH_BITS;
   logic [PINS-1:0] port_pin_irq_pending;
   logic [PB-1:0]   periph_pending_reg;
   logic [PINS-1:0] edge_polarity_reg;
   logic [PINS-1:0] port_choice_reg;
   logic [PINS-1:0] wake_enable_reg;
   logic [PINS-1:0] port_a_input_data;
   logic [PINS-1:0] port_d_input_data;
   logic            global_enable_reg;
   logic            wake_flag_reg;
   logic [PINS-1:0] sel_prev_reg;
   logic [2*PINS-1:0] filt_reg;
   logic [2*PINS-1:0] filt_prev_reg;
   logic [7:0]      glitch_cnt_reg;
   logic [15:0]     recov_cnt_reg;
   logic            recovering_reg;

   typedef enum logic [1:0] {RUN, HALT, RECOVER} power_state_t;
   power_state_t    pstate_reg;

   // Index of the register addressed by the byte address.
   function automatic logic [11:0] word_index(
      input logic [irq_wake_pkg::ADDR_W-1:0] addr);
      word_index = addr[irq_wake_pkg::ADDR_W-1:2];
   endfunction : word_index

   logic            wr_access;
   logic            rd_access;
   logic [11:0]     idx;
   logic [PINS-1:0] sel_pins;
   logic [PINS-1:0] pin_event;
   logic            sampling;
   logic [2*PINS-1:0] raw_pins;

   assign idx       = word_index(paddr);
   assign wr_access = psel & penable & pwrite;
   assign rd_access = psel & penable & ~pwrite;
   assign raw_pins  = {port_d_pins, port_a_pins};
   // Input data registers freeze while halted or recovering.
   assign sampling  = (pstate_reg == RUN);                        // [RULE_13]
   // Per-source choice between the port A and port D pin.
   assign sel_pins  = (port_choice_reg & port_d_input_data)
                    | (~port_choice_reg & port_a_input_data);     // [RULE_09]
   // Polarity zero sees a one-to-zero step; one sees zero-to-one.
   assign pin_event = sampling ?
      ((edge_polarity_reg & sel_pins & ~sel_prev_reg)
       | (~edge_polarity_reg & ~sel_pins & sel_prev_reg))
      : '0;                                            // [RULE_06] [RULE_07]

   // ----------------------------------------------------------------------
   // Port input data, sampled only in run state
   // ----------------------------------------------------------------------
   // Both ports are captured so that either one can feed a source.
   // A pin that wakes the part lands here only at the end of recovery,
   // and only if it still holds its new level then.
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         port_a_input_data <= irq_wake_pkg::CFG_RESET;
         port_d_input_data <= irq_wake_pkg::CFG_RESET;
         sel_prev_reg      <= irq_wake_pkg::CFG_RESET;
      end else if (sampling) begin                                 // [RULE_14]
         port_a_input_data <= port_a_pins;
         port_d_input_data <= port_d_pins;
         sel_prev_reg      <= sel_pins;
      end
   end

   // ----------------------------------------------------------------------
   // Pin pending register
   // ----------------------------------------------------------------------
   // Hardware set wins over a software clear in the same cycle.
   // A software write of one sets a bit, a write of zero clears it.
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         port_pin_irq_pending <= irq_wake_pkg::PEND_RESET;         // [RULE_04]
      end else if (wr_access && idx == irq_wake_pkg::PIN_PEND_IDX) begin
         port_pin_irq_pending <= pwdata[PINS-1:0] | pin_event;     // [RULE_15]
      end else begin
         port_pin_irq_pending <= port_pin_irq_pending | pin_event; // [RULE_01]
      end
   end

   // ----------------------------------------------------------------------
   // Peripheral pending register
   // ----------------------------------------------------------------------
   // Bit order: 6 timer1, 5 timer0, 4 rx, 3 tx, 2 twowire, 1 spi, 0 adc.
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         periph_pending_reg <= '0;
      end else if (wr_access && idx == irq_wake_pkg::PERIPH_IDX) begin
         periph_pending_reg <= pwdata[PB-1:0] | periph_req;        // [RULE_15]
      end else begin
         periph_pending_reg <= periph_pending_reg | periph_req;    // [RULE_05]
      end
   end

   // ----------------------------------------------------------------------
   // Configuration registers
   // ----------------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         edge_polarity_reg <= irq_wake_pkg::CFG_RESET;
         port_choice_reg   <= irq_wake_pkg::CFG_RESET;
         wake_enable_reg   <= irq_wake_pkg::CFG_RESET;
         global_enable_reg <= 1'b0;
      end else if (wr_access) begin
         case (idx)
            irq_wake_pkg::EDGE_POL_IDX: edge_polarity_reg <= pwdata[PINS-1:0];
            irq_wake_pkg::PORT_SEL_IDX: port_choice_reg   <= pwdata[PINS-1:0];
            irq_wake_pkg::WAKE_EN_IDX:  wake_enable_reg   <= pwdata[PINS-1:0];
            irq_wake_pkg::CTRL_IDX:
               global_enable_reg <= pwdata[irq_wake_pkg::CTRL_GIE];
            default: ;
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // Wake filter
   // ----------------------------------------------------------------------
   // Pins are held in a register and a change counts only once the
   // new level stood for the glitch window, so short spikes are dropped.
   // One counter serves all sixteen pins, so a pin that keeps toggling
   // delays the wake of another; this trades wake latency for area.
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         filt_reg       <= '0;
         filt_prev_reg  <= '0;
         glitch_cnt_reg <= '0;
      end else begin
         filt_prev_reg <= raw_pins;
         if (raw_pins != filt_prev_reg) begin
            glitch_cnt_reg <= '0;
         end else if (glitch_cnt_reg < 8'(irq_wake_pkg::GLITCH_CYC - 1)) begin
            glitch_cnt_reg <= glitch_cnt_reg + 8'd1;
         end else begin
            filt_reg <= raw_pins;                                  // [RULE_11]
         end
      end
   end

   // Filtered levels are compared against the frozen input data.
   logic any_wake;
   assign any_wake = |((filt_reg ^ {port_d_input_data, port_a_input_data})
                       & {wake_enable_reg, wake_enable_reg});      // [RULE_10]

   // ----------------------------------------------------------------------
   // Power state and recovery
   // ----------------------------------------------------------------------
   // Recovery counts RECOVERY cycles before the input data sample again.
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         pstate_reg    <= RUN;
         recov_cnt_reg <= '0;
         wake_start    <= 1'b0;
      end else begin
         wake_start <= 1'b0;
         case (pstate_reg)
            RUN: begin
               if (halt_enter) begin
                  pstate_reg <= HALT;
               end
            end
            HALT: begin
               if (any_wake) begin                                 // [RULE_10]
                  pstate_reg    <= RECOVER;
                  recov_cnt_reg <= '0;
                  wake_start    <= 1'b1;
               end
            end
            RECOVER: begin
               if (recov_cnt_reg >= 16'(RECOVERY - 1)) begin
                  pstate_reg <= RUN;                               // [RULE_14]
               end else begin
                  recov_cnt_reg <= recov_cnt_reg + 16'd1;
               end
            end
            default: pstate_reg <= RUN;
         endcase
      end
   end

   // Halt wake flag, set by a pin wake, cleared by writing a one.
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         wake_flag_reg <= 1'b0;
      end else if (pstate_reg == HALT && any_wake) begin
         wake_flag_reg <= 1'b1;                                    // [RULE_12]
      end else if (wr_access && idx == irq_wake_pkg::CTRL_IDX &&
                   pwdata[irq_wake_pkg::CTRL_WAKE_FLAG]) begin
         wake_flag_reg <= 1'b0;
      end
   end

   // ----------------------------------------------------------------------
   // Requests to the CPU
   // ----------------------------------------------------------------------
   // Gated by the global enable; pending bits stay visible regardless.
   // Registered so the CPU sees a clean level, one cycle behind pending.
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         pin_irq_to_cpu    <= '0;
         periph_irq_to_cpu <= '0;
         halted            <= 1'b0;
      end else begin
         pin_irq_to_cpu    <= global_enable_reg ?
                              port_pin_irq_pending : '0;  // [RULE_02] [RULE_03]
         periph_irq_to_cpu <= global_enable_reg ? periph_pending_reg : '0;
         halted            <= (pstate_reg != RUN);
      end
   end

   // ----------------------------------------------------------------------
   // APB read side
   // ----------------------------------------------------------------------
   // Zero wait states; unmapped reads return zero with pslverr.
   // Read data is latched in the setup cycle and shown in the access cycle.
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel & ~penable;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
         if (psel && !penable) begin
            case (word_index(paddr))
               irq_wake_pkg::PIN_PEND_IDX:
                  prdata[PINS-1:0] <= port_pin_irq_pending;        // [RULE_03]
               irq_wake_pkg::PERIPH_IDX:  prdata[PB-1:0] <= periph_pending_reg;
               irq_wake_pkg::EDGE_POL_IDX:
                  prdata[PINS-1:0] <= edge_polarity_reg;
               irq_wake_pkg::PORT_SEL_IDX: prdata[PINS-1:0] <= port_choice_reg;
               irq_wake_pkg::WAKE_EN_IDX:  prdata[PINS-1:0] <= wake_enable_reg;
               irq_wake_pkg::PORT_A_IN_IDX:
                  prdata[PINS-1:0] <= port_a_input_data;
               irq_wake_pkg::PORT_D_IN_IDX:
                  prdata[PINS-1:0] <= port_d_input_data;
               irq_wake_pkg::CTRL_IDX: begin
                  prdata[irq_wake_pkg::CTRL_GIE]       <= global_enable_reg;
                  prdata[irq_wake_pkg::CTRL_HALT]      <= (pstate_reg != RUN);
                  prdata[irq_wake_pkg::CTRL_WAKE_FLAG] <= wake_flag_reg;
               end
               default: pslverr <= 1'b1;
            endcase
         end
      end
   end

   logic unused_rd;
   assign unused_rd = rd_access;

endmodule : irq_request_and_pin_wake

// file: dv/irq_wake_checker.sv
// Purpose: Port-level assertions for the request and pin wake block.
// Assumes: One clock, asynchronous active-low reset.
// Notes:   Global enable is mirrored from APB writes to the control word.
`timescale 1ns/100ps
module irq_wake_checker #(
   parameter int PINS     = 8,  // Pins per port.
   parameter int RECOVERY = 16  // Recovery cycles.
) (
   input wire logic                                   ref_clk,  // Clock.
   input wire logic                                   rst_b,    // Reset.
   input wire logic [irq_wake_pkg::ADDR_W-1:0]        paddr,    // Address.
   input wire logic                                   psel,     // Select.
   input wire logic                                   penable,  // Enable.
   input wire logic                                   pwrite,   // Write.
   input wire logic [31:0]                            pwdata,   // Wdata.
   input wire logic [31:0]                            prdata,   // Rdata.
   input wire logic                                   pready,   // Ready.
   input wire logic                                   pslverr,  // Error.
   input wire logic [irq_wake_pkg::PERIPH_BITS-1:0]   periph_req, // Req.
   input wire logic                                   halt_enter, // Halt.
   input wire logic [PINS-1:0]                        pin_irq_to_cpu, // Pin.
   input wire logic [irq_wake_pkg::PERIPH_BITS-1:0] periph_irq_to_cpu, // Irq.
   input wire logic                                   halted,   // Halted.
   input wire logic                                   wake_start // Wake.
);
   localparam int REC_MAX = RECOVERY + 8;
   logic gie;

   // Mirror of global enable; it changes at the write access edge only.
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b)
         gie <= 1'b0;
      else if (psel && penable && pwrite &&
               paddr[irq_wake_pkg::ADDR_W-1:2] == irq_wake_pkg::CTRL_IDX)
         gie <= pwdata[irq_wake_pkg::CTRL_GIE];
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_b);

   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_req_live;
      (gie && |periph_req) ##1 gie;
   endsequence

   a_ready_pulse: assert property (pready |=> !pready)
      else $error("pready held longer than one cycle");
   a_ready_timely: assert property (s_setup |=> pready)
      else $error("no answer in first access cycle");
   a_err_zero: assert property (pslverr |-> pready && prdata == 0)
      else $error("error response carries data");
   a_irq_gated: assert property (!gie && !$past(gie) |->
      pin_irq_to_cpu == 0 && periph_irq_to_cpu == 0)
      else $error("request forwarded while disabled");
   a_periph_fwd: assert property (s_req_live |=>
      (periph_irq_to_cpu & $past(periph_req, 2)) == $past(periph_req, 2))
      else $error("peripheral request not forwarded");
   a_halt_enter: assert property (
      !halted && halt_enter |-> ##2 halted)
      else $error("halt not entered");
   a_wake_halted: assert property (wake_start |-> halted)
      else $error("wake outside halt");
   a_wake_bound: assert property (
      wake_start |-> ##[1:REC_MAX] !halted)
      else $error("recovery too long");
endmodule : irq_wake_checker

bind irq_request_and_pin_wake irq_wake_checker #(
   .PINS(PINS), .RECOVERY(RECOVERY)) u_chk (
   .ref_clk(ref_clk), .rst_b(rst_b), .paddr(paddr), .psel(psel),
   .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .periph_req(periph_req),
   .halt_enter(halt_enter), .pin_irq_to_cpu(pin_irq_to_cpu),
   .periph_irq_to_cpu(periph_irq_to_cpu), .halted(halted),
   .wake_start(wake_start));

// file: dv/pin_drive_model.sv
// Purpose: Behavioural model of the GPIO pins facing the block.
// Assumes: Pin levels are synchronous to ref_clk.
// Notes:   Levels launch on the clock edge, so no pulse is under a clock.
`timescale 1ns/100ps
module pin_drive_model (
   input  wire logic       ref_clk,     // System clock.
   input  wire logic [7:0] a_lvl,       // Wanted port A levels.
   input  wire logic [7:0] d_lvl,       // Wanted port D levels.
   output logic      [7:0] port_a_pins, // Port A pins.
   output logic      [7:0] port_d_pins  // Port D pins.
);
   // Each level is held whole cycles, at least one clock.
   always_ff @(posedge ref_clk) begin
      port_a_pins <= a_lvl;
      port_d_pins <= d_lvl;
   end
endmodule : pin_drive_model

// file: dv/tb_irq_request_and_pin_wake.sv
// Purpose: Self-checking bench for the request and pin wake block.
// Assumes: Zero wait APB slave; recovery shortened to 8 cycles.
// Notes:   Random data comes from a fixed-seed shift register.
`timescale 1ns/100ps
module tb_irq_request_and_pin_wake;
   logic        ref_clk, rst_b, psel, penable, pwrite, pready, pslverr;
   logic        halt_enter, halted, wake_start, er;
   logic [13:0] paddr;
   logic [31:0] pwdata, prdata, rd, v;
   logic [7:0]  a_lvl, d_lvl, pa, pd, pin_irq;
   logic [6:0]  periph_req, periph_irq;
   int          failures, checks, n, p, s;

   irq_request_and_pin_wake #(.RECOVERY(8)) u_dut (
      .ref_clk(ref_clk), .rst_b(rst_b), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .port_a_pins(pa),
      .port_d_pins(pd), .periph_req(periph_req), .halt_enter(halt_enter),
      .pin_irq_to_cpu(pin_irq), .periph_irq_to_cpu(periph_irq),
      .halted(halted), .wake_start(wake_start));
   pin_drive_model u_pins (.ref_clk(ref_clk), .a_lvl(a_lvl), .d_lvl(d_lvl),
      .port_a_pins(pa), .port_d_pins(pd));

   // Free-running clock.
   always #2.5 ref_clk = ~ref_clk;

   function logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction : lfsr

   task chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         failures++;
         $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   // One APB transfer; the request holds until pready is sampled high.
   task apb(input logic w, input logic [11:0] idx, input logic [31:0] d);
      int k;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {idx, 2'b00};
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge ref_clk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      if (pready !== 1'b1) failures++;
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge ref_clk);
   endtask : apb

   task rd_chk(input logic [11:0] idx, input logic [31:0] exp);
      apb(1'b0, idx, 32'h0000_0000);
      chk(rd, exp);
   endtask : rd_chk

   task print_verdict;
      $display("checks=%0d failures=%0d", checks, failures);
      if (failures == 0 && checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : print_verdict

   // Watchdog: the tests need about 1100 cycles, 20000 is ample.
   initial begin
      #100000;
      failures++;
      print_verdict();
   end

   // Main sequence.
   initial begin
      ref_clk = 0; rst_b = 0; psel = 0; penable = 0; pwrite = 0;
      paddr = 0; pwdata = 0; periph_req = 0; halt_enter = 0;
      a_lvl = 0; d_lvl = 0; failures = 0; checks = 0; v = 32'h0000_e1c4;
      repeat (4) @(posedge ref_clk);
      rst_b <= 1'b1;
      @(posedge ref_clk);
      rd_chk(irq_wake_pkg::PIN_PEND_IDX, 0);
      rd_chk(irq_wake_pkg::PERIPH_IDX, 0);
      apb(1'b0, 12'h0abc, 32'h0000_0000);
      chk({31'h0, er}, 1);
      repeat (4) begin
         v = lfsr(v);
         apb(1'b1, irq_wake_pkg::PIN_PEND_IDX, {24'h0, v[7:0]});
         rd_chk(irq_wake_pkg::PIN_PEND_IDX, {24'h0, v[7:0]});
         chk({24'h0, pin_irq}, 0);
      end
      apb(1'b1, irq_wake_pkg::PIN_PEND_IDX, 0);
      // Every peripheral source alone, with global enable clear.
      for (n = 0; n < 7; n++) begin
         periph_req <= 7'h01 << n;
         @(posedge ref_clk);
         periph_req <= 7'h00;
         rd_chk(irq_wake_pkg::PERIPH_IDX, 32'h1 << n);
         chk({25'h0, periph_irq}, 0);
         apb(1'b1, irq_wake_pkg::PERIPH_IDX, 0);
      end
      apb(1'b1, irq_wake_pkg::CTRL_IDX, 1);
      v = lfsr(v);
      periph_req <= v[6:0] | 7'h01;
      @(posedge ref_clk);
      periph_req <= 7'h00;
      repeat (3) @(posedge ref_clk);
      chk({25'h0, periph_irq}, {25'h0, v[6:0] | 7'h01});
      apb(1'b1, irq_wake_pkg::PIN_PEND_IDX, {24'h0, v[15:8]});
      @(posedge ref_clk);
      chk({24'h0, pin_irq}, {24'h0, v[15:8]});
      apb(1'b1, irq_wake_pkg::CTRL_IDX, 0);
      apb(1'b1, irq_wake_pkg::PIN_PEND_IDX, 0);
      apb(1'b1, irq_wake_pkg::PERIPH_IDX, 0);
      // Every pin, polarity and port choice; the other port must not count.
      for (int k = 0; k < 32; k++) begin
         n = k % 8; p = (k / 8) % 2; s = k / 16;
         apb(1'b1, irq_wake_pkg::EDGE_POL_IDX, p ? 32'h1 << n : 0);
         apb(1'b1, irq_wake_pkg::PORT_SEL_IDX, s ? 32'h1 << n : 0);
         a_lvl <= {8{p == 0}};
         d_lvl <= {8{p == 0}};
         repeat (4) @(posedge ref_clk);
         apb(1'b1, irq_wake_pkg::PIN_PEND_IDX, 0);
         if (s) a_lvl[n] <= p[0]; else d_lvl[n] <= p[0];
         repeat (4) @(posedge ref_clk);
         rd_chk(irq_wake_pkg::PIN_PEND_IDX, 0);
         if (s) d_lvl[n] <= p[0]; else a_lvl[n] <= p[0];
         repeat (4) @(posedge ref_clk);
         rd_chk(irq_wake_pkg::PIN_PEND_IDX, 32'h1 << n);
      end
      // Halt, a frozen input register, then a wake from pin 3 of port A.
      apb(1'b1, irq_wake_pkg::PORT_SEL_IDX, 0);
      apb(1'b1, irq_wake_pkg::EDGE_POL_IDX, 32'h0000_0008);
      a_lvl <= 8'h00;
      repeat (4) @(posedge ref_clk);
      apb(1'b1, irq_wake_pkg::PIN_PEND_IDX, 0);
      apb(1'b1, irq_wake_pkg::WAKE_EN_IDX, 32'h0000_0008);
      halt_enter <= 1'b1;
      @(posedge ref_clk);
      halt_enter <= 1'b0;
      a_lvl[5] <= 1'b1;
      repeat (6) @(posedge ref_clk);
      rd_chk(irq_wake_pkg::PORT_A_IN_IDX, 0);
      chk({31'h0, halted}, 1);
      // A two-cycle spike on the wake pin is filtered out.
      a_lvl[3] <= 1'b1;
      repeat (2) @(posedge ref_clk);
      a_lvl[3] <= 1'b0;
      repeat (12) @(posedge ref_clk);
      apb(1'b0, irq_wake_pkg::CTRL_IDX, 0);
      chk({31'h0, rd[2]}, 0);
      chk({31'h0, halted}, 1);
      a_lvl[3] <= 1'b1;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (wake_start !== 1'b1 && n < 60);
      chk({31'h0, wake_start}, 1);
      apb(1'b0, irq_wake_pkg::CTRL_IDX, 0);
      chk({31'h0, rd[2]}, 1);
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (halted !== 1'b0 && n < 60);
      chk({31'h0, halted}, 0);
      repeat (4) @(posedge ref_clk);
      rd_chk(irq_wake_pkg::PORT_A_IN_IDX, 32'h0000_0028);
      rd_chk(irq_wake_pkg::PIN_PEND_IDX, 32'h0000_0008);
      apb(1'b1, irq_wake_pkg::CTRL_IDX, 32'h0000_0004);
      apb(1'b0, irq_wake_pkg::CTRL_IDX, 0);
      chk({31'h0, rd[2]}, 0);
      // A three-cycle pulse wakes the part and sets the wake flag, but leaves no pending bit.
      apb(1'b1, irq_wake_pkg::PIN_PEND_IDX, 0);
      halt_enter <= 1'b1;
      @(posedge ref_clk);
      halt_enter <= 1'b0;
      a_lvl[3] <= 1'b0;
      repeat (3) @(posedge ref_clk);
      a_lvl[3] <= 1'b1;
      repeat (30) @(posedge ref_clk);
      chk({31'h0, halted}, 0);
      apb(1'b0, irq_wake_pkg::CTRL_IDX, 0);
      chk({31'h0, rd[2]}, 1);
      rd_chk(irq_wake_pkg::PORT_A_IN_IDX, 32'h0000_0028);
      rd_chk(irq_wake_pkg::PIN_PEND_IDX, 32'h0000_0000);
      print_verdict();
   end
endmodule : tb_irq_request_and_pin_wake
